// ===== verilog/lin_phy_regs_pkg.sv
package lin_phy_regs_pkg;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [2:0] OFS_DATA    = 3'h0;
  localparam logic [2:0] OFS_CONTROL = 3'h1;
  localparam logic [2:0] OFS_TEST_A  = 3'h2;
  localparam logic [2:0] OFS_EDGE    = 3'h3;
  localparam logic [2:0] OFS_TEST_B  = 3'h4;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int TX_DRIVE_POS   = 1;
  localparam int RX_STATE_POS   = 0;
  localparam int ENABLE_POS     = 3;
  localparam int RX_ONLY_POS    = 2;
  localparam int WAKEUP_POS     = 1;
  localparam int PULLUP_POS     = 0;
  localparam int DT_DISABLE_POS = 7;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic       TX_DRIVE_RST = 1'b1;
  localparam logic [3:0] CONTROL_RST  = 4'h0;
  localparam logic       DT_DIS_RST   = 1'b0;
  localparam logic [1:0] EDGE_RST     = 2'h0;
  localparam logic [7:0] TEST_RST     = 8'h00;

  // ---------------------------------------------------------------
  // Edge-rate encodings
  // ---------------------------------------------------------------
  localparam logic [1:0] EDGE_NORMAL = 2'h0;
  localparam logic [1:0] EDGE_SLOW   = 2'h1;
  localparam logic [1:0] EDGE_FAST   = 2'h2;
  localparam logic [1:0] EDGE_RSVD   = 2'h3;

  // ---------------------------------------------------------------
  // Wake-up timing
  // ---------------------------------------------------------------
  localparam int WAKE_FILTER_NS  = 100;
  localparam int CLK_PERIOD_NS   = 4;
  localparam int WAKE_FILTER_CYC = (WAKE_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAKE_PULSE_NS   = 16;
  localparam int WAKE_PULSE_CYC  = WAKE_PULSE_NS / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    MODE_SHUTDOWN,
    MODE_NORMAL,
    MODE_RX_ONLY,
    MODE_STANDBY
  } phy_mode_t;

endpackage

// ===== verilog/lin_phy_control_registers.sv
`timescale 1ns/1ps

module lin_phy_control_registers
(
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  // Register port
  input  wire logic [2:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // Chip state
  input  wire logic       special_mode,
  input  wire logic       standby_req,
  input  wire logic       tx_route_sel,
  input  wire logic       tx_ext_in,
  // Bus receiver (asynchronous comparator output)
  input  wire logic       bus_level_in,
  // Transceiver controls
  output logic            tx_input_line,
  output logic            tx_drive_en,
  output logic            rx_output_line,
  output logic            strong_pullup_on,
  output logic            weak_pullup_on,
  output logic      [1:0] edge_rate_field,
  output logic            dominant_timeout_disable,
  output logic            receiver_on,
  output logic            wakeup_armed
);

  typedef struct packed {
    logic [1:0]                      bus_sync;
    logic                            stby_sync_a;
    logic                            stby_sync_b;
    logic                            tx_drive_bit;
    logic                            phy_enable;
    logic                            receive_only_sel;
    logic                            wakeup_enable;
    logic                            strong_pullup_sel;
    logic                            dt_disable;
    logic [1:0]                      edge_rate;
    logic [7:0]                      test_a;
    logic [7:0]                      test_b;
    logic [7:0]                      rdata;
    logic [7:0]                      dom_cnt;
    logic                            dom_long;
    logic [3:0]                      pulse_cnt;
    logic                            tx_line;
    logic                            tx_en;
    logic                            rx_line;
    logic                            pu_strong;
    logic                            pu_weak;
    logic                            rx_on;
    logic                            wk_armed;
  } state_t;

  state_t s_q;
  state_t s_d;

  lin_phy_regs_pkg::phy_mode_t mode;
  logic                        bus_lvl;
  logic                        wr_data;
  logic                        wr_ctrl;
  logic                        wr_edge;
  logic                        wr_test_a;
  logic                        wr_test_b;
  logic                        tx_src;
  logic                        rx_now;

  function automatic logic hit(input logic [2:0] addr, input logic [2:0] ofs);
    hit = (addr == ofs);
  endfunction

  // ---------------------------------------------------------------
  // Mode decode
  // ---------------------------------------------------------------
  always_comb
  begin
    if (!s_q.phy_enable)
      mode = lin_phy_regs_pkg::MODE_SHUTDOWN;
    else if (s_q.stby_sync_b)
      mode = lin_phy_regs_pkg::MODE_STANDBY;
    else if (s_q.receive_only_sel)
      mode = lin_phy_regs_pkg::MODE_RX_ONLY;
    else
      mode = lin_phy_regs_pkg::MODE_NORMAL;
  end

  assign bus_lvl   = s_q.bus_sync[1];
  assign wr_data   = reg_wr && hit(reg_addr, lin_phy_regs_pkg::OFS_DATA);
  assign wr_ctrl   = reg_wr && hit(reg_addr, lin_phy_regs_pkg::OFS_CONTROL);
  // Slew may not change mid-transmission, so only shutdown can update it
  assign wr_edge   = reg_wr && hit(reg_addr, lin_phy_regs_pkg::OFS_EDGE)
                     && !s_q.phy_enable;
  assign wr_test_a = reg_wr && hit(reg_addr, lin_phy_regs_pkg::OFS_TEST_A)
                     && special_mode;
  assign wr_test_b = reg_wr && hit(reg_addr, lin_phy_regs_pkg::OFS_TEST_B)
                     && special_mode;
  assign tx_src    = tx_route_sel ? s_q.tx_drive_bit : tx_ext_in;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb
  begin
    s_d             = s_q;
    s_d.bus_sync    = {s_q.bus_sync[0], bus_level_in};
    s_d.stby_sync_a = standby_req;
    s_d.stby_sync_b = s_q.stby_sync_a;
    rx_now          = 1'b1;

    // data and control writable in every mode
    if (wr_data)
      s_d.tx_drive_bit = reg_wdata[lin_phy_regs_pkg::TX_DRIVE_POS];
    if (wr_ctrl)
    begin
      s_d.phy_enable        = reg_wdata[lin_phy_regs_pkg::ENABLE_POS];
      s_d.receive_only_sel  = reg_wdata[lin_phy_regs_pkg::RX_ONLY_POS];
      s_d.wakeup_enable     = reg_wdata[lin_phy_regs_pkg::WAKEUP_POS];
      s_d.strong_pullup_sel = reg_wdata[lin_phy_regs_pkg::PULLUP_POS];
    end
    if (wr_edge)
    begin
      s_d.dt_disable = reg_wdata[lin_phy_regs_pkg::DT_DISABLE_POS];
      s_d.edge_rate  = reg_wdata[1:0];
    end
    if (wr_test_a)
      s_d.test_a = reg_wdata;
    if (wr_test_b)
      s_d.test_b = reg_wdata;

    // Wake-up filter: dominant (low) must outlast the filter, then rise
    if (mode == lin_phy_regs_pkg::MODE_STANDBY && s_q.wakeup_enable && !bus_lvl)
    begin
      if (s_q.dom_cnt != 8'(lin_phy_regs_pkg::WAKE_FILTER_CYC))
        s_d.dom_cnt = s_q.dom_cnt + 8'h01;
      else
        s_d.dom_long = 1'b1;
    end
    else
    begin
      s_d.dom_cnt  = 8'h00;
      s_d.dom_long = 1'b0;
    end
    if (mode == lin_phy_regs_pkg::MODE_STANDBY && s_q.wakeup_enable
        && s_q.dom_long && bus_lvl)
      s_d.pulse_cnt = 4'(lin_phy_regs_pkg::WAKE_PULSE_CYC);
    else if (s_q.pulse_cnt != 4'h0)
      s_d.pulse_cnt = s_q.pulse_cnt - 4'h1;

    unique case (mode)
      lin_phy_regs_pkg::MODE_SHUTDOWN:
      begin
        s_d.tx_line   = 1'b1;
        s_d.tx_en     = 1'b0;
        s_d.pu_strong = 1'b0;
        s_d.pu_weak   = 1'b1;
        s_d.rx_on     = 1'b0;
        s_d.wk_armed  = 1'b0;
        rx_now        = 1'b1;
      end
      lin_phy_regs_pkg::MODE_NORMAL:
      begin
        s_d.tx_line   = tx_src;
        s_d.tx_en     = 1'b1;
        s_d.pu_strong = s_q.strong_pullup_sel;
        s_d.pu_weak   = !s_q.strong_pullup_sel;
        s_d.rx_on     = 1'b1;
        s_d.wk_armed  = 1'b0;
        rx_now        = bus_lvl;
      end
      lin_phy_regs_pkg::MODE_RX_ONLY:
      begin
        s_d.tx_line   = 1'b1;
        s_d.tx_en     = 1'b0;
        s_d.pu_strong = s_q.strong_pullup_sel;
        s_d.pu_weak   = !s_q.strong_pullup_sel;
        s_d.rx_on     = 1'b1;
        s_d.wk_armed  = 1'b0;
        rx_now        = bus_lvl;
      end
      lin_phy_regs_pkg::MODE_STANDBY:
      begin
        s_d.tx_line   = 1'b1;
        s_d.tx_en     = 1'b0;
        s_d.pu_strong = s_q.strong_pullup_sel && s_q.wakeup_enable;
        s_d.pu_weak   = !(s_q.strong_pullup_sel && s_q.wakeup_enable);
        s_d.rx_on     = 1'b0;
        s_d.wk_armed  = s_q.wakeup_enable;
        // Receiver idles high; only the wake-up pulse drives it low
        rx_now        = (s_q.pulse_cnt == 4'h0);
      end
    endcase
    s_d.rx_line = rx_now;

    // Read data valid in the cycle after the strobe only
    s_d.rdata = 8'h00;
    if (reg_rd)
    begin
      unique case (reg_addr)
        lin_phy_regs_pkg::OFS_DATA:
          s_d.rdata = {6'h00, s_q.tx_drive_bit, s_q.rx_line};
        lin_phy_regs_pkg::OFS_CONTROL:
          s_d.rdata = {4'h0, s_q.phy_enable, s_q.receive_only_sel,
                       s_q.wakeup_enable, s_q.strong_pullup_sel};
        lin_phy_regs_pkg::OFS_TEST_A:
          s_d.rdata = s_q.test_a;
        lin_phy_regs_pkg::OFS_EDGE:
          s_d.rdata = {s_q.dt_disable, 5'h00, s_q.edge_rate};
        lin_phy_regs_pkg::OFS_TEST_B:
          s_d.rdata = s_q.test_b;
        default:
          s_d.rdata = 8'h00;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_q                   <= '0;
      s_q.bus_sync          <= 2'h3;
      s_q.tx_drive_bit      <= lin_phy_regs_pkg::TX_DRIVE_RST;
      {s_q.phy_enable, s_q.receive_only_sel, s_q.wakeup_enable,
       s_q.strong_pullup_sel} <= lin_phy_regs_pkg::CONTROL_RST;
      s_q.dt_disable        <= lin_phy_regs_pkg::DT_DIS_RST;
      s_q.edge_rate         <= lin_phy_regs_pkg::EDGE_RST;
      s_q.test_a            <= lin_phy_regs_pkg::TEST_RST;
      s_q.test_b            <= lin_phy_regs_pkg::TEST_RST;
      s_q.tx_line           <= 1'b1;
      s_q.rx_line           <= 1'b1;
      s_q.pu_weak           <= 1'b1;
    end
    else
      s_q <= s_d;
  end

  assign reg_rdata                = s_q.rdata;
  assign tx_input_line            = s_q.tx_line;
  assign tx_drive_en              = s_q.tx_en;
  assign rx_output_line           = s_q.rx_line;
  assign strong_pullup_on         = s_q.pu_strong;
  assign weak_pullup_on           = s_q.pu_weak;
  assign edge_rate_field          = s_q.edge_rate;
  assign dominant_timeout_disable = s_q.dt_disable;
  assign receiver_on              = s_q.rx_on;
  assign wakeup_armed             = s_q.wk_armed;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  property p_edge_locked;
    @(posedge clk_sys) disable iff (!rst_n)
      (reg_wr && reg_addr == lin_phy_regs_pkg::OFS_EDGE && s_q.phy_enable)
      |=> $stable(edge_rate_field) && $stable(dominant_timeout_disable);
  endproperty
  a_edge_locked: assert property (p_edge_locked)
    else $error("edge rate changed while enabled");

  property p_edge_write;
    @(posedge clk_sys) disable iff (!rst_n)
      (reg_wr && reg_addr == lin_phy_regs_pkg::OFS_EDGE && !s_q.phy_enable)
      |=> edge_rate_field == $past(reg_wdata[1:0])
          && dominant_timeout_disable == $past(reg_wdata[7]);
  endproperty
  a_edge_write: assert property (p_edge_write) else $error("edge rate write lost");

  property p_shutdown_pullup;
    @(posedge clk_sys) disable iff (!rst_n)
      !s_q.phy_enable |=> weak_pullup_on && !strong_pullup_on && !tx_drive_en;
  endproperty
  a_shutdown_pullup: assert property (p_shutdown_pullup)
    else $error("shutdown outputs wrong");

  property p_ctrl_write;
    @(posedge clk_sys) disable iff (!rst_n)
      (reg_wr && reg_addr == lin_phy_regs_pkg::OFS_CONTROL)
      ##1 (reg_rd && reg_addr == lin_phy_regs_pkg::OFS_CONTROL)
      |=> reg_rdata == {4'h0, $past(reg_wdata[3:0], 2)};
  endproperty
  a_ctrl_write: assert property (p_ctrl_write) else $error("control readback wrong");

  property p_rx_read;
    @(posedge clk_sys) disable iff (!rst_n)
      (reg_rd && reg_addr == lin_phy_regs_pkg::OFS_DATA)
      |=> reg_rdata[0] == $past(rx_output_line);
  endproperty
  a_rx_read: assert property (p_rx_read) else $error("receiver bit wrong");

  property p_test_locked;
    @(posedge clk_sys) disable iff (!rst_n)
      (reg_wr && reg_addr == lin_phy_regs_pkg::OFS_TEST_B && !special_mode)
      |=> $stable(s_q.test_b);
  endproperty
  a_test_locked: assert property (p_test_locked) else $error("test register written");

  property p_tx_normal_only;
    @(posedge clk_sys) disable iff (!rst_n)
      (mode != lin_phy_regs_pkg::MODE_NORMAL) |=> tx_input_line && !tx_drive_en;
  endproperty
  a_tx_normal_only: assert property (p_tx_normal_only)
    else $error("transmit outside normal");

  property p_tx_drive;
    @(posedge clk_sys) disable iff (!rst_n)
      (mode == lin_phy_regs_pkg::MODE_NORMAL && tx_route_sel)
      |=> tx_input_line == $past(s_q.tx_drive_bit);
  endproperty
  a_tx_drive: assert property (p_tx_drive) else $error("data bit not driving transmit");

  property p_wake_pulse;
    @(posedge clk_sys) disable iff (!rst_n)
      $fell(rx_output_line) && mode == lin_phy_regs_pkg::MODE_STANDBY
      |-> ##[1:8] rx_output_line;
  endproperty
  a_wake_pulse: assert property (p_wake_pulse) else $error("wake pulse too long");

  c_wake:     cover property (@(posedge clk_sys) disable iff (!rst_n)
                mode == lin_phy_regs_pkg::MODE_STANDBY && $fell(rx_output_line));
  c_edge_wr:  cover property (@(posedge clk_sys) disable iff (!rst_n) wr_edge);
  c_rx_only:  cover property (@(posedge clk_sys) disable iff (!rst_n)
                mode == lin_phy_regs_pkg::MODE_RX_ONLY);
  c_normal:   cover property (@(posedge clk_sys) disable iff (!rst_n)
                mode == lin_phy_regs_pkg::MODE_NORMAL && !tx_input_line);

endmodule

// ===== dv/lin_bus_node.sv
`timescale 1ns/1ps

// ---------------------------------------------------------------
// Single-wire bus with one remote node
// ---------------------------------------------------------------
module lin_bus_node
(
  // Device transmitter
  input  wire logic drv_en,
  input  wire logic drv_level,
  // Remote node request
  input  wire logic node_dominant,
  // Wire level, 1 recessive
  output logic      bus_level
);
  // Wired-AND: the pullup returns the wire to recessive once both release it
  assign bus_level = ~((drv_en & ~drv_level) | node_dominant);
endmodule

// ===== dv/tb_lin_phy_control_registers.sv
`timescale 1ns/1ps

module tb_lin_phy_control_registers;
  logic       clk_sys      = 1'b0;
  logic       rst_n        = 1'b0;
  logic [2:0] reg_addr     = 3'h0;
  logic [7:0] reg_wdata    = 8'h00;
  logic       reg_wr       = 1'b0;
  logic       reg_rd       = 1'b0;
  logic [7:0] reg_rdata;
  logic       special_mode = 1'b0;
  logic       standby_req  = 1'b0;
  logic       tx_route_sel = 1'b1;
  logic       tx_ext_in    = 1'b1;
  logic       node_dom     = 1'b0;
  logic       bus_level_in;
  logic       tx_input_line, tx_drive_en, rx_output_line, strong_pullup_on, weak_pullup_on;
  logic [1:0] edge_rate_field;
  logic       dominant_timeout_disable, receiver_on, wakeup_armed;
  int         errors       = 0;
  int         n_compared   = 0;
  int         cnt;
  logic       seen_low;

  typedef struct {logic [2:0] a; logic [7:0] w; logic sp; logic [7:0] e;} row_t;
  // Writes made in shutdown, each followed by a read of the same place
  row_t rows [12] = '{
    '{3'h2, 8'h5a, 1'b0, 8'h00}, '{3'h2, 8'h5a, 1'b1, 8'h5a},
    '{3'h4, 8'ha5, 1'b0, 8'h00}, '{3'h4, 8'ha5, 1'b1, 8'ha5},
    '{3'h5, 8'hff, 1'b1, 8'h00}, '{3'h1, 8'hf7, 1'b0, 8'h07},
    '{3'h0, 8'hfc, 1'b0, 8'h01}, '{3'h3, 8'h01, 1'b0, 8'h01},
    '{3'h3, 8'h00, 1'b0, 8'h00}, '{3'h3, 8'hff, 1'b0, 8'h83},
    '{3'h3, 8'h02, 1'b0, 8'h02}, '{3'h3, 8'h82, 1'b0, 8'h82}};

  always #2 clk_sys = ~clk_sys;

  lin_bus_node bus (.drv_en(tx_drive_en), .drv_level(tx_input_line),
                    .node_dominant(node_dom), .bus_level(bus_level_in));

  lin_phy_control_registers dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .special_mode(special_mode),
    .standby_req(standby_req), .tx_route_sel(tx_route_sel), .tx_ext_in(tx_ext_in),
    .bus_level_in(bus_level_in), .tx_input_line(tx_input_line), .tx_drive_en(tx_drive_en),
    .rx_output_line(rx_output_line), .strong_pullup_on(strong_pullup_on),
    .weak_pullup_on(weak_pullup_on), .edge_rate_field(edge_rate_field),
    .dominant_timeout_disable(dominant_timeout_disable), .receiver_on(receiver_on),
    .wakeup_armed(wakeup_armed));

  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD %0t value %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_pin(input logic got, input logic exp, input string what);
    n_compared++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD %0t pin %s is %b", $time, what, got);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d, input logic sp = 1'b0);
    @(posedge clk_sys);
    reg_addr     <= a;
    reg_wdata    <= d;
    special_mode <= sp;
    reg_wr       <= 1'b1;
    @(posedge clk_sys);
    reg_wr       <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rchk(input logic [2:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    #1;
    chk_reg(reg_rdata, exp);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic pulse_bus(input int n);
    @(posedge clk_sys);
    node_dom <= 1'b1;
    repeat (n) @(posedge clk_sys);
    node_dom <= 1'b0;
    #1;
  endtask

  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // A wait that runs out of its bound ends the run as a mismatch
  task automatic time_out(input string what);
    errors++;
    $display("BAD %0t timeout %s", $time, what);
    close_out();
  endtask

  initial
  begin
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    settle(2);
    chk_pin(tx_drive_en, 1'b0, "drive");
    chk_pin(weak_pullup_on, 1'b1, "weak");
    chk_pin(strong_pullup_on, 1'b0, "strong");
    rchk(3'h0, 8'h03);
    rchk(3'h1, 8'h00);
    rchk(3'h3, 8'h00);
    $display("reset test done");
    foreach (rows[i])
    begin
      wr(rows[i].a, rows[i].w, rows[i].sp);
      // Read strobe follows the write strobe with no idle cycle
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1;
      chk_reg(reg_rdata, rows[i].e);
    end
    chk_reg({6'h00, edge_rate_field}, 8'h02);
    chk_pin(dominant_timeout_disable, 1'b1, "dt");
    $display("table test done");
    // Edge-rate settings locked once enabled
    wr(3'h1, 8'h08);
    wr(3'h3, 8'h01);
    rchk(3'h3, 8'h82);
    chk_reg({6'h00, edge_rate_field}, 8'h02);
    // Normal mode: data bit 1 drives the wire
    wr(3'h0, 8'h00);
    settle(8);
    chk_pin(tx_drive_en, 1'b1, "drive");
    chk_pin(tx_input_line, 1'b0, "tx");
    chk_pin(rx_output_line, 1'b0, "rx");
    rchk(3'h0, 8'h00);
    @(posedge clk_sys);
    tx_route_sel <= 1'b0;
    settle(4);
    chk_pin(tx_input_line, 1'b1, "tx");
    @(posedge clk_sys);
    tx_route_sel <= 1'b1;
    wr(3'h1, 8'h09);
    settle(3);
    chk_pin(strong_pullup_on, 1'b1, "strong");
    chk_pin(weak_pullup_on, 1'b0, "weak");
    $display("normal test done");
    // Receive-only ignores the transmit source but still listens
    wr(3'h1, 8'h0c);
    settle(8);
    chk_pin(tx_drive_en, 1'b0, "drive");
    chk_pin(tx_input_line, 1'b1, "tx");
    chk_pin(receiver_on, 1'b1, "rxon");
    pulse_bus(8);
    chk_pin(rx_output_line, 1'b0, "rx");
    wr(3'h1, 8'h01);
    settle(3);
    chk_pin(strong_pullup_on, 1'b0, "strong");
    chk_pin(receiver_on, 1'b0, "rxon");
    rchk(3'h1, 8'h01);
    $display("rx-only and shutdown test done");
    // Standby with wake-up: long dominant then release
    wr(3'h1, 8'h0b);
    @(posedge clk_sys);
    standby_req <= 1'b1;
    settle(6);
    chk_pin(wakeup_armed, 1'b1, "armed");
    chk_pin(strong_pullup_on, 1'b1, "strong");
    chk_pin(tx_drive_en, 1'b0, "drive");
    pulse_bus(40);
    cnt = 0;
    for (int k = 0; k < 30 && rx_output_line !== 1'b0; k++)
      settle(1);
    if (rx_output_line !== 1'b0)
      time_out("no wake pulse");
    for (int k = 0; k < 20 && rx_output_line === 1'b0; k++)
    begin
      cnt++;
      settle(1);
    end
    if (rx_output_line !== 1'b1)
      time_out("wake pulse stuck");
    chk_reg(8'(cnt), 8'(lin_phy_regs_pkg::WAKE_PULSE_CYC));
    wr(3'h1, 8'h09);
    settle(3);
    chk_pin(wakeup_armed, 1'b0, "armed");
    chk_pin(strong_pullup_on, 1'b0, "strong");
    pulse_bus(40);
    seen_low = 1'b0;
    repeat (30)
    begin
      settle(1);
      if (rx_output_line !== 1'b1)
        seen_low = 1'b1;
    end
    chk_pin(seen_low, 1'b0, "wake");
    rchk(3'h1, 8'h09);
    $display("standby test done");
    // Mid-run reset returns every setting to its idle value
    @(posedge clk_sys);
    rst_n <= 1'b0;
    settle(3);
    chk_pin(tx_drive_en, 1'b0, "drive");
    chk_pin(wakeup_armed, 1'b0, "armed");
    chk_reg({6'h00, edge_rate_field}, {6'h00, lin_phy_regs_pkg::EDGE_RST});
    @(posedge clk_sys);
    rst_n <= 1'b1;
    settle(2);
    chk_pin(weak_pullup_on, 1'b1, "weak");
    rchk(3'h1, {4'h0, lin_phy_regs_pkg::CONTROL_RST});
    rchk(3'h3, 8'h00);
    $display("mid-run reset test done");
    close_out();
  end
endmodule
